// file: design/standby_wake_interrupt_detect.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module standby_wake_interrupt_detect
	import wake_detect_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	// Wake sources
	input wire logic [NUM_PIN-1:0] pin_in_i,
	input wire logic [NUM_PIN-1:0] pin_in_en_i,
	input wire logic [NUM_PERIPH-1:0] periph_wake_i,
	// Direct peripheral requests
	input wire logic [NUM_MATCH-1:0] timer_match_irq_i,
	input wire logic [NUM_CAP-1:0] timer_capture_irq_i,
	input wire logic converter_done_irq_i,
	input wire logic sync_serial_irq_i,
	input wire logic dma_error_irq_i,
	input wire logic dma_done_irq_i,
	// Lines to processor interrupt controller
	output logic [NUM_WAKE-1:0] wake_line_o,
	output logic [FWD_W-1:0] fwd_irq_o,
	output logic standby_release_o,
	// Block interrupt
	output logic irq_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	bus_state_t bus_state;
	logic [FIELD_W-1:0] wake_mode_control_reg [NUM_WAKE];
	logic [NUM_WAKE-1:0] wake_source_enable;
	logic [SEL_W-1:0] wake_active_level_sel [NUM_WAKE];
	logic [NUM_WAKE-1:0] src_sig;
	logic [NUM_WAKE-1:0] raw_line;
	logic [NUM_WAKE-1:0] det_req;
	logic [NUM_WAKE-1:0] req_q;
	logic [NUM_WAKE-1:0] clear_hit;
	logic [NUM_WAKE-1:0] status;
	logic [NUM_WAKE-1:0] mask;
	logic [NUM_WAKE-1:0] next_status;
	logic [FWD_W-1:0] next_fwd;
	logic accept;
	logic wr_acc;
	logic rd_acc;
	logic status_rd;
	logic mask_wr;
	logic clear_wr;
	logic [31:0] next_rdata;
	logic [31:0] mode_lo_word;
	logic [31:0] mode_hi_word;

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// Request answered one cycle after it is seen
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			bus_state <= BUS_IDLE;
			waitrequest_o <= 1'b1;
		end else begin
			case (bus_state)
				BUS_IDLE: begin
					if (read_i || write_i) begin
						bus_state <= BUS_ANSWER;
						waitrequest_o <= 1'b0;
					end
				end
				BUS_ANSWER: begin
					bus_state <= BUS_IDLE;
					waitrequest_o <= 1'b1;
				end
				default: begin
					bus_state <= BUS_IDLE;
					waitrequest_o <= 1'b1;
				end
			endcase
		end
	end

	assign accept = (bus_state == BUS_ANSWER) && !waitrequest_o;
	assign wr_acc = accept && write_i;
	assign rd_acc = accept && read_i;
	assign status_rd = rd_acc && (address_i == STATUS_OFS);
	assign mask_wr = wr_acc && (address_i == MASK_OFS) && byteenable_i[0];
	assign clear_wr = wr_acc && (address_i == CLEAR_OFS) && byteenable_i[0];

	// ----------------------------------------------------------------
	// Per-channel configuration and detection
	// ----------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < NUM_WAKE; ch++) begin : g_ch
			localparam bit CH_IS_PIN = (ch < NUM_PIN);
			localparam logic [7:0] CH_OFS = (ch < CH_PER_REG) ? MODE_LO_OFS : MODE_HI_OFS;
			localparam int CH_BYTE = ch % CH_PER_REG;

			// Mode byte, written through its byte lane
			always_ff @(posedge mclk_i) begin
				if (sys_rst_i) begin
					wake_mode_control_reg[ch] <= MODE_RST;
				end else if (wr_acc && address_i == CH_OFS && byteenable_i[CH_BYTE]) begin
					wake_mode_control_reg[ch] <= writedata_i[CH_BYTE*FIELD_W +: FIELD_W];
				end
			end

			assign wake_source_enable[ch] = wake_mode_control_reg[ch][EN_BIT];
			assign wake_active_level_sel[ch] = wake_mode_control_reg[ch][SEL_LSB +: SEL_W];
			assign clear_hit[ch] = clear_wr && (writedata_i[CLR_IDX_W-1:0] == CLR_IDX_W'(ch));

			// Disabled pin buffer forces a high input
			if (CH_IS_PIN) begin : g_pin
				assign src_sig[ch] = pin_in_en_i[ch] ? pin_in_i[ch] : 1'b1;
			end else begin : g_per
				assign src_sig[ch] = periph_wake_i[ch-NUM_PIN];
			end

			wake_detector #(
				.IS_PIN(CH_IS_PIN)
			) u_det (
				.mclk_i(mclk_i),
				.sys_rst_i(sys_rst_i),
				.sig_i(src_sig[ch]),
				.enable_i(wake_source_enable[ch]),
				.level_sel_i(wake_active_level_sel[ch]),
				.clear_i(clear_hit[ch]),
				.req_o(det_req[ch])
			);

			// Enabled: detector result; else raw source passes through
			assign raw_line[ch] = wake_source_enable[ch] ? det_req[ch] : src_sig[ch];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Lines to the processor
	// ----------------------------------------------------------------
	// Wake lines and standby release summary
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			wake_line_o <= '0;
			standby_release_o <= 1'b0;
			req_q <= '0;
		end else begin
			wake_line_o <= raw_line;
			standby_release_o <= |(det_req & wake_source_enable);
			req_q <= det_req;
		end
	end

	// Map direct requests onto source numbers
	always_comb begin
		next_fwd = '0;
		for (int i = 0; i < NUM_MATCH; i++) begin
			next_fwd[MATCH_FIRST - FWD_FIRST + i] = timer_match_irq_i[i];
		end
		for (int i = 0; i < NUM_CAP_A; i++) begin
			next_fwd[CAP_A_FIRST - FWD_FIRST + i] = timer_capture_irq_i[i];
		end
		for (int i = 0; i < NUM_CAP_B; i++) begin
			next_fwd[CAP_B_FIRST - FWD_FIRST + i] = timer_capture_irq_i[NUM_CAP_A + i];
		end
		next_fwd[CONV_SRC - FWD_FIRST] = converter_done_irq_i;
		next_fwd[SERIAL_SRC - FWD_FIRST] = sync_serial_irq_i;
		next_fwd[DMA_ERR_SRC - FWD_FIRST] = dma_error_irq_i;
		next_fwd[DMA_DONE_SRC - FWD_FIRST] = dma_done_irq_i;
	end

	// Forwarded lines, active high while requesting
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			fwd_irq_o <= '0;
		end else begin
			fwd_irq_o <= next_fwd;
		end
	end

	// ----------------------------------------------------------------
	// Event status, mask and interrupt
	// ----------------------------------------------------------------
	// Read clears only reported bits; set beats read-clear
	assign next_status = (status & ~(readdata_o[NUM_WAKE-1:0] & {NUM_WAKE{status_rd}})) | (det_req & ~req_q);

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	// Mask register
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			mask <= MASK_RST;
		end else if (mask_wr) begin
			mask <= writedata_i[NUM_WAKE-1:0];
		end
	end

	// Level interrupt output
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(next_status & mask);
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Gather mode bytes into words
	always_comb begin
		mode_lo_word = '0;
		mode_hi_word = '0;
		for (int i = 0; i < NUM_WAKE; i++) begin
			if (i < CH_PER_REG) begin
				mode_lo_word[i*FIELD_W +: FIELD_W] = wake_mode_control_reg[i];
			end else begin
				mode_hi_word[(i-CH_PER_REG)*FIELD_W +: FIELD_W] = wake_mode_control_reg[i];
			end
		end
	end

	// Address decode; unmapped reads zero
	always_comb begin
		next_rdata = '0;
		case (address_i)
			MODE_LO_OFS: begin
				next_rdata = mode_lo_word;
			end
			MODE_HI_OFS: begin
				next_rdata = mode_hi_word;
			end
			STATUS_OFS: begin
				next_rdata[NUM_WAKE-1:0] = status;
			end
			MASK_OFS: begin
				next_rdata[NUM_WAKE-1:0] = mask;
			end
			REQ_OFS: begin
				next_rdata[NUM_WAKE-1:0] = det_req;
			end
			default: begin
				next_rdata = '0;
			end
		endcase
	end

	// Data captured when the request is first seen
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			readdata_o <= RDATA_RST;
		end else if (bus_state == BUS_IDLE && read_i) begin
			readdata_o <= next_rdata;
		end
	end

endmodule : standby_wake_interrupt_detect
`default_nettype wire

// file: design/wake_detect_pkg.sv
package wake_detect_pkg;

	// ----------------------------------------------------------------
	// Channel counts
	// ----------------------------------------------------------------
	localparam int NUM_PIN = 4;
	localparam int NUM_PERIPH = 4;
	localparam int NUM_WAKE = NUM_PIN + NUM_PERIPH;
	localparam int CH_PER_REG = 4;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] MODE_LO_OFS = 8'h00;
	localparam logic [7:0] MODE_HI_OFS = 8'h04;
	localparam logic [7:0] CLEAR_OFS = 8'h10;
	localparam logic [7:0] STATUS_OFS = 8'h14;
	localparam logic [7:0] MASK_OFS = 8'h18;
	localparam logic [7:0] REQ_OFS = 8'h1c;

	// ----------------------------------------------------------------
	// Per-channel byte of a mode register
	// ----------------------------------------------------------------
	localparam int FIELD_W = 8;
	localparam int EN_BIT = 0;
	localparam int SEL_LSB = 1;
	localparam int SEL_W = 2;
	localparam int CLR_IDX_W = 3;

	// Active level codes; peripheral channels use bit 0 only
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_HIGH = 2'h1;
	localparam logic [1:0] LVL_FALL = 2'h2;
	localparam logic [1:0] LVL_RISE = 2'h3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Forwarded source numbering
	// ----------------------------------------------------------------
	localparam int FWD_FIRST = 43;
	localparam int FWD_LAST = 99;
	localparam int FWD_W = FWD_LAST - FWD_FIRST + 1;
	localparam int MATCH_FIRST = 43;
	localparam int NUM_MATCH = 13;
	localparam int CAP_A_FIRST = 74;
	localparam int NUM_CAP_A = 4;
	localparam int CAP_B_FIRST = 80;
	localparam int NUM_CAP_B = 8;
	localparam int NUM_CAP = NUM_CAP_A + NUM_CAP_B;
	localparam int CONV_SRC = 58;
	localparam int SERIAL_SRC = 59;
	localparam int DMA_ERR_SRC = 98;
	localparam int DMA_DONE_SRC = 99;

	// Bus answer state
	typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

endpackage : wake_detect_pkg

// file: design/wake_detector.sv
`timescale 1ns/1ps
`default_nettype none
module wake_detector
	import wake_detect_pkg::*;
#(
	parameter bit IS_PIN = 1'b1
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Source and configuration
	input wire logic sig_i,
	input wire logic enable_i,
	input wire logic [SEL_W-1:0] level_sel_i,
	input wire logic clear_i,
	// Detected request
	output logic req_o
);

	logic prev;
	logic rise;
	logic fall;
	logic edge_hit;
	logic next_req;

	// Previous sample for edge detection
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			prev <= 1'b0;
		end else begin
			prev <= sig_i;
		end
	end

	assign rise = sig_i & ~prev;
	assign fall = ~sig_i & prev;
	// Peripheral: only edges; bit 0 picks the edge
	assign edge_hit = level_sel_i[0] ? rise : fall;

	// Level follows input, edge latches until cleared
	always_comb begin
		next_req = 1'b0;
		if (enable_i) begin
			if (IS_PIN && !level_sel_i[1]) begin
				next_req = level_sel_i[0] ? sig_i : ~sig_i;
			end else begin
				next_req = (req_o & ~clear_i) | edge_hit;
			end
		end
	end

	// Request flop, high while requesting
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			req_o <= 1'b0;
		end else begin
			req_o <= next_req;
		end
	end

endmodule : wake_detector
`default_nettype wire

// file: bench/wake_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module wake_cpu_model #(
	parameter int N = 1
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Request lines and acknowledge
	input wire logic [N-1:0] line_i,
	input wire logic [N-1:0] ack_i,
	// Pending view
	output logic [N-1:0] pending_o
);
	// High level on a line marks it pending until acknowledged
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			pending_o <= '0;
		end else begin
			pending_o <= (pending_o & ~ack_i) | line_i;
		end
	end
endmodule : wake_cpu_model
`default_nettype wire

// file: bench/standby_wake_interrupt_detect_checker.sv
`timescale 1ns/1ps
`default_nettype none
module standby_wake_interrupt_detect_checker
	import wake_detect_pkg::*;
(
	// Clock, reset and bus
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic waitrequest_o,
	// Direct sources
	input wire logic [NUM_MATCH-1:0] timer_match_irq_i,
	input wire logic [NUM_CAP-1:0] timer_capture_irq_i,
	input wire logic converter_done_irq_i,
	input wire logic sync_serial_irq_i,
	input wire logic dma_error_irq_i,
	input wire logic dma_done_irq_i,
	// Outputs
	input wire logic [FWD_W-1:0] fwd_irq_o,
	input wire logic irq_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	// Request waiting, and a cycle after reset
	sequence s_req;
		(read_i || write_i) && waitrequest_o;
	endsequence
	sequence s_live;
		!$past(sys_rst_i);
	endsequence
	chk_wait_answer: assert property (s_req |=> !waitrequest_o)
		else $error("bus answer late");
	chk_wait_once: assert property (!waitrequest_o |=> waitrequest_o)
		else $error("bus accept too long");
	chk_reset_idle: assert property (disable iff (1'b0) sys_rst_i |=> waitrequest_o && !irq_o)
		else $error("outputs not idle in reset");
	chk_match_order: assert property (s_live |-> fwd_irq_o[12:0] == $past(timer_match_irq_i))
		else $error("match lines misplaced");
	chk_capture_slots: assert property (s_live |-> {fwd_irq_o[44:37], fwd_irq_o[34:31]}
		== $past(timer_capture_irq_i))
		else $error("capture lines misplaced");
	chk_gap_reserved: assert property (fwd_irq_o[36:35] == 2'h0)
		else $error("reserved capture slot high");
	chk_unused_low: assert property ({fwd_irq_o[54:45], fwd_irq_o[30:17], fwd_irq_o[14:13]} == 26'h0)
		else $error("unused line high");
	chk_direct_high: assert property (s_live |-> {fwd_irq_o[56:55], fwd_irq_o[16:15]} ==
		$past({dma_done_irq_i, dma_error_irq_i, sync_serial_irq_i, converter_done_irq_i}))
		else $error("direct request not high");
endmodule : standby_wake_interrupt_detect_checker
bind standby_wake_interrupt_detect standby_wake_interrupt_detect_checker u_chk (.mclk_i(mclk_i),
	.sys_rst_i(sys_rst_i), .read_i(read_i), .write_i(write_i), .waitrequest_o(waitrequest_o),
	.timer_match_irq_i(timer_match_irq_i), .timer_capture_irq_i(timer_capture_irq_i),
	.converter_done_irq_i(converter_done_irq_i), .sync_serial_irq_i(sync_serial_irq_i),
	.dma_error_irq_i(dma_error_irq_i), .dma_done_irq_i(dma_done_irq_i),
	.fwd_irq_o(fwd_irq_o), .irq_o(irq_o));
`default_nettype wire

// file: bench/test_standby_wake_interrupt_detect.sv
`timescale 1ns/1ps
`default_nettype none
module test_standby_wake_interrupt_detect
	import wake_detect_pkg::*;
;
	logic clk = 0, rst = 1, rd = 0, wr = 0, wq, sr, irq;
	logic [7:0] adr = 8'h0, wl;
	logic [31:0] wd = 32'h0, rq, rdat;
	logic [3:0] be = 4'h0, pin = 4'h0, pen = 4'hf, pw = 4'h0;
	logic [28:0] src = 29'h0;
	logic [FWD_W-1:0] fw, pend;
	int error_cnt = 0, tests_run = 0;
	// ----------------------------------------------------------------
	// Harness
	// ----------------------------------------------------------------
	initial begin
		forever #25 clk = !clk;
	end
	standby_wake_interrupt_detect u_dut (.mclk_i(clk), .sys_rst_i(rst), .address_i(adr), .read_i(rd),
		.write_i(wr), .writedata_i(wd), .byteenable_i(be), .readdata_o(rq), .waitrequest_o(wq),
		.pin_in_i(pin), .pin_in_en_i(pen), .periph_wake_i(pw), .timer_match_irq_i(src[12:0]),
		.timer_capture_irq_i(src[24:13]), .converter_done_irq_i(src[25]), .sync_serial_irq_i(src[26]),
		.dma_error_irq_i(src[27]), .dma_done_irq_i(src[28]), .wake_line_o(wl), .fwd_irq_o(fw),
		.standby_release_o(sr), .irq_o(irq));
	wake_cpu_model #(.N(FWD_W)) u_cpu (.mclk_i(clk), .sys_rst_i(rst), .line_i(fw), .ack_i('0),
		.pending_o(pend));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(string n, logic [63:0] e, logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : check
	// One bus cycle, held until waitrequest is sampled low
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] b);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		be <= b;
		do @(posedge clk); while (wq !== 1'b0);
		rdat = rq;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hf);
		check(n, e, rdat);
	endtask : rchk
	task automatic drive(int ch, logic v);
		if (ch < 4) pin[ch] <= v;
		else pw[ch-4] <= v;
	endtask : drive
	task automatic mode(int ch, logic [7:0] f);
		bus(1'b1, ch > 3 ? MODE_HI_OFS : MODE_LO_OFS, 32'(f) << (8 * (ch % 4)), 4'h1 << (ch % 4));
		repeat (2) @(posedge clk);
	endtask : mode
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset;
		check("wait", 1'b1, wq);
		check("fwd", 64'h0, fw);
		rchk("mode_lo", MODE_LO_OFS, 32'h0);
		rchk("mode_hi", MODE_HI_OFS, 32'h0);
		rchk("mask", MASK_OFS, 32'h0);
		rchk("unmapped", 8'h08, 32'h0);
		$display("end reset test");
	endtask : test_reset
	// Clear, arm, fire, release and clear one channel
	task automatic test_mode(int ch, logic [1:0] code);
		logic edg;
		edg = (ch > 3) || code[1];
		drive(ch, !code[0]);
		repeat (3) @(posedge clk);
		bus(1'b1, CLEAR_OFS, 32'(ch), 4'h1);
		mode(ch, {5'h0, code, 1'b1});
		rchk("idle", REQ_OFS, 32'h0);
		drive(ch, code[0]);
		repeat (3) @(posedge clk);
		rchk("fire", REQ_OFS, 32'h1 << ch);
		check("release", 1'b1, sr);
		check("line", 1'b1, wl[ch]);
		drive(ch, !code[0]);
		repeat (3) @(posedge clk);
		rchk("hold", REQ_OFS, 32'(edg) << ch);
		bus(1'b1, CLEAR_OFS, 32'(ch), 4'h1);
		repeat (2) @(posedge clk);
		rchk("clear", REQ_OFS, 32'h0);
		check("release_off", 1'b0, sr);
		mode(ch, 8'h0);
		$display("end mode test %0d %0d", ch, code);
	endtask : test_mode
	task automatic test_gate;
		pen[2] <= 1'b0;
		mode(2, 8'h03);
		repeat (2) @(posedge clk);
		check("gated_line", 1'b1, wl[2]);
		rchk("gated_req", REQ_OFS, 32'h4);
		pen[2] <= 1'b1;
		mode(2, 8'h0);
		$display("end gate test");
	endtask : test_gate
	task automatic test_irq;
		bus(1'b0, STATUS_OFS, 32'h0, 4'hf);
		bus(1'b1, CLEAR_OFS, 32'h7, 4'h1);
		mode(7, 8'h03);
		pw[3] <= 1'b1;
		repeat (3) @(posedge clk);
		check("masked", 1'b0, irq);
		bus(1'b1, MASK_OFS, 32'h80, 4'h1);
		rchk("mask_rd", MASK_OFS, 32'h80);
		check("irq_on", 1'b1, irq);
		rchk("status", STATUS_OFS, 32'h80);
		repeat (2) @(posedge clk);
		check("irq_off", 1'b0, irq);
		rchk("status_clr", STATUS_OFS, 32'h0);
		$display("end irq test");
	endtask : test_irq
	// Walk one source at a time through the forwarded numbering
	task automatic test_fwd;
		int p;
		logic [63:0] all;
		all = 64'h0;
		for (int i = 0; i < 29; i++) begin
			p = i < 13 ? i : i < 17 ? i + 18 : i < 25 ? i + 20 : i < 27 ? i - 10 : i + 28;
			all[p] = 1'b1;
			src <= 29'h1 << i;
			repeat (2) @(posedge clk);
			check("fwd", 64'h1 << p, fw);
		end
		@(posedge clk);
		check("pending", all, pend);
		$display("end forward test");
	endtask : test_fwd
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	// ----------------------------------------------------------------
	// Sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		test_reset();
		for (int c = 0; c < 4; c++) test_mode(0, 2'(c));
		test_mode(5, 2'h0);
		test_mode(6, 2'h1);
		test_gate();
		test_irq();
		test_fwd();
		complete_run();
	end
	initial begin
		#1000000;
		error_cnt++;
		complete_run();
	end
endmodule : test_standby_wake_interrupt_detect
`default_nettype wire
